/* srcc_params.svh */
/*
 * Constants for the shift/rotate condition-code block: control-store bit
 * positions, operand bit positions, selector codes and reset values.
 * Assumes it is included by bare name, before the package and the modules.
 */
//------------------------------------------------------------------------------
// Contract
//------------------------------------------------------------------------------
// Contract
// - Two select lines pick ror, asr, rol, asl; both selector halves always enabled.
// - Select lines come from control store bits 28 and 29, inverted.
// - Rotate negative: shift sign for left ops, bit 15 for asr, carry for ror.
// - Serial bit into B: zero for asl, carry for rotates, bit 15 for asr.
// - Shift-right carry takes bit 00; rotate carry-out feeds all four operations.
// - Shift overflow is new negative XOR new carry.
// - Arithmetic carry/overflow lookup is disabled during shift-right; gating supplies flags.
// - The XOR overflow term passes only when the rotate category is asserted.
// - Arithmetic shifts are rotate-category words; negative comes from rotate negative.
// - Zero-detect enable: bit 00 for asl, bit 15 for asr, bit 15 with carry for rotates.
// - Rotate-category word zero comes from the gated shift zero detector.
// - Negate: carry is nonzero result, overflow only at 100000 octal, usual N and Z.
// - Plain word operations take zero from an all-sixteen-bits zero detector.
// - Negative/zero selector uses byte as high select, rotate category as low.
// - Computed flags load through a two-way selector under aux bit 24 and load strobe.
`ifndef SRCC_PARAMS_SVH
`define SRCC_PARAMS_SVH

// Widths and operand bit positions.
`define SRCC_WORD_W 16
`define SRCC_MW_W 32
`define SRCC_MSB 15
`define SRCC_LSB 0
`define SRCC_BYTE_MSB 7
`define SRCC_ZD_LO 1
`define SRCC_ZD_HI 14
`define SRCC_BZD_HI 6

// Control store bit positions; these bits are active low.
`define SRCC_CS_S1_BIT 28
`define SRCC_CS_S0_BIT 29
`define SRCC_CS_AUX_BIT 24

// Shift and rotate selector codes, {s1, s0}.
`define SRCC_SEL_ROR 2'h0
`define SRCC_SEL_ASR 2'h1
`define SRCC_SEL_ROL 2'h2
`define SRCC_SEL_ASL 2'h3

// Negate overflow result, octal 100000.
`define SRCC_NEG_OVF 16'h8000
`define SRCC_WORD_ZERO 16'h0000

// Flag positions on the direct load path from the ALU output mux.
`define SRCC_ALU_OUTPUT_MUX_C 0
`define SRCC_ALU_OUTPUT_MUX_V 1
`define SRCC_ALU_OUTPUT_MUX_Z 2
`define SRCC_ALU_OUTPUT_MUX_N 3

// Reset values.
`define SRCC_FLAG_RST 1'h0
`define SRCC_SERIAL_ZERO 1'h0

`endif

/* srcc_pkg.sv */
/*
 * Types shared by the condition-code block and its rotate selector.
 * Assumes srcc_params.svh is on the include path.
 */
`default_nettype none
`include "srcc_params.svh"

package srcc_pkg;

   typedef enum logic [1:0] {
      SRCC_ROR = `SRCC_SEL_ROR,
      SRCC_ASR = `SRCC_SEL_ASR,
      SRCC_ROL = `SRCC_SEL_ROL,
      SRCC_ASL = `SRCC_SEL_ASL
   } srcc_sel_t;

   typedef struct packed {
      logic flag_n;
      logic flag_z;
      logic flag_v;
      logic flag_c;
      logic serial;
   } srcc_state_t;

endpackage

`default_nettype wire

/* srcc_rot_if.sv */
/*
 * Carrier between the flag logic and the rotate selector.
 * Assumes the package srcc_pkg is compiled first.
 */
`default_nettype none

interface srcc_rot_if;
   srcc_pkg::srcc_sel_t sel;
   logic [15:0] b_reg;
   logic [15:0] b_leg;
   logic carry;
   logic shift_sign;
   logic rot_neg;
   logic rot_cout;
   logic serial_in;
   logic zero_en;

   modport mux (input sel, b_reg, b_leg, carry, shift_sign,
                output rot_neg, rot_cout, serial_in, zero_en);
   modport user (output sel, b_reg, b_leg, carry, shift_sign,
                 input rot_neg, rot_cout, serial_in, zero_en);
endinterface

`default_nettype wire

/* srcc_rot_mux.sv */
/*
 * Rotate selectors: carry-out, rotate negative, serial input to the B
 * register and the enable of the shift zero detector.
 * Assumes a single-cycle select from the flag logic; purely combinational.
 */
`default_nettype none
`include "srcc_params.svh"

module srcc_rot_mux
(
   // Selector carrier
   srcc_rot_if.mux rot
);
   import srcc_pkg::*;

   //---------------------------------------------------------------------------
   // Selectors
   //---------------------------------------------------------------------------
   // Both halves have no enable, so every code produces an answer.
   always_comb
   begin
      rot.rot_neg = rot.carry;
      rot.rot_cout = rot.b_reg[`SRCC_LSB];
      rot.serial_in = rot.carry;
      rot.zero_en = ~(rot.b_leg[`SRCC_MSB] | rot.carry);
      case (rot.sel)
         SRCC_ASL:
         begin
            rot.rot_neg = rot.shift_sign;
            rot.rot_cout = rot.b_reg[`SRCC_MSB];
            rot.serial_in = `SRCC_SERIAL_ZERO;
            rot.zero_en = ~rot.b_leg[`SRCC_LSB];
         end
         SRCC_ROL:
         begin
            rot.rot_neg = rot.shift_sign;
            rot.rot_cout = rot.b_reg[`SRCC_MSB];
            rot.serial_in = rot.carry;
            rot.zero_en = ~(rot.b_leg[`SRCC_MSB] | rot.carry);
         end
         SRCC_ASR:
         begin
            rot.rot_neg = rot.b_reg[`SRCC_MSB];
            rot.rot_cout = rot.b_reg[`SRCC_LSB];
            rot.serial_in = rot.b_reg[`SRCC_MSB];
            rot.zero_en = ~rot.b_leg[`SRCC_MSB];
         end
         SRCC_ROR:
         begin
            rot.rot_neg = rot.carry;
            rot.rot_cout = rot.b_reg[`SRCC_LSB];
            rot.serial_in = rot.carry;
            rot.zero_en = ~(rot.b_leg[`SRCC_MSB] | rot.carry);
         end
         default:
         begin
            rot.rot_neg = rot.carry;
            rot.rot_cout = rot.b_reg[`SRCC_LSB];
            rot.serial_in = rot.carry;
            rot.zero_en = ~(rot.b_leg[`SRCC_MSB] | rot.carry);
         end
      endcase
   end

endmodule // srcc_rot_mux

`default_nettype wire

/* srcc_top.sv */
/*
 * Condition-code logic for shift, rotate and plain word operations: selects
 * negative, zero, overflow and carry and loads them into the status flags.
 * Assumes all inputs come from logic on clk_in and settle within one cycle;
 * the microprogram never mixes an ALU function with a shift flag step.
 */
`default_nettype none
`include "srcc_params.svh"

module srcc_top
(
   // Clock and reset
   input wire logic clk_in,
   input wire logic rst_in,
   // Microword and strobes
   input wire logic [31:0] microword_in,
   input wire logic load_status_in,
   // Instruction category
   input wire logic byte_operation_in,
   input wire logic rotate_category_in,
   input wire logic negate_op_in,
   // Datapath
   input wire logic [15:0] alu_output_mux_in,
   input wire logic [15:0] b_register_in,
   input wire logic [15:0] b_leg_a_in,
   input wire logic left_shift_sign_in,
   // Arithmetic carry/overflow lookup
   input wire logic arith_carry_in,
   input wire logic arith_overflow_in,
   // Status flags
   output logic flag_n_out,
   output logic flag_z_out,
   output logic flag_v_out,
   output logic flag_c_out,
   // Serial bit into the B register
   output logic serial_shift_in_out
);
   import srcc_pkg::*;

   srcc_state_t state_reg;
   srcc_state_t state_next;
   srcc_rot_if rot ();
   srcc_sel_t rot_sel;
   logic lookup_en;
   logic word_zero;
   logic low_byte_zero;
   logic shift_zero;
   logic byte_shift_zero;
   logic nz_neg;
   logic nz_zero;
   logic calc_c;
   logic calc_v;
   logic computed_sel;

   //---------------------------------------------------------------------------
   // Rotate selectors
   //---------------------------------------------------------------------------
   // The select lines are the ALU function bits; they are only meaningful here
   // in steps that compute shift flags, never while the ALU function is used.
   assign rot_sel = srcc_sel_t'({~microword_in[`SRCC_CS_S1_BIT],
                                 ~microword_in[`SRCC_CS_S0_BIT]});
   assign rot.sel = rot_sel;
   assign rot.b_reg = b_register_in;
   assign rot.b_leg = b_leg_a_in;
   assign rot.carry = state_reg.flag_c;
   assign rot.shift_sign = left_shift_sign_in;

   srcc_rot_mux u_rot_mux
   (
      .rot (rot.mux)
   );

   //---------------------------------------------------------------------------
   // Zero detectors
   //---------------------------------------------------------------------------
   assign word_zero = (alu_output_mux_in == `SRCC_WORD_ZERO);
   assign low_byte_zero = ~|alu_output_mux_in[`SRCC_BYTE_MSB:`SRCC_LSB];
   // The shift detector looks only at the inner bits; the enable covers the
   // edge bit that the operation moves, which keeps the detector narrow.
   assign shift_zero = rot.zero_en & ~|b_leg_a_in[`SRCC_ZD_HI:`SRCC_ZD_LO];
   assign byte_shift_zero = rot.zero_en & ~|b_leg_a_in[`SRCC_BZD_HI:`SRCC_ZD_LO];

   //---------------------------------------------------------------------------
   // Flag computation
   //---------------------------------------------------------------------------
   // Aux bit is active low; low picks the computed flags.
   assign computed_sel = ~microword_in[`SRCC_CS_AUX_BIT];
   // The lookup is held off for every shift or rotate, shift-right included.
   assign lookup_en = ~rotate_category_in;

   always_comb
   begin
      state_next = state_reg;
      case ({byte_operation_in, rotate_category_in})
         2'h0:
         begin
            nz_neg = alu_output_mux_in[`SRCC_MSB];
            nz_zero = word_zero;
         end
         2'h1:
         begin
            nz_neg = rot.rot_neg;
            nz_zero = shift_zero;
         end
         2'h2:
         begin
            nz_neg = alu_output_mux_in[`SRCC_BYTE_MSB];
            nz_zero = low_byte_zero;
         end
         2'h3:
         begin
            nz_neg = rot.rot_neg;
            nz_zero = byte_shift_zero;
         end
         default:
         begin
            nz_neg = alu_output_mux_in[`SRCC_MSB];
            nz_zero = word_zero;
         end
      endcase
      // Wired-OR of the lookup and the rotate gating.
      calc_c = (lookup_en & arith_carry_in) | (rotate_category_in & rot.rot_cout);
      calc_v = (lookup_en & arith_overflow_in)
               | (rotate_category_in & (nz_neg ^ rot.rot_cout));
      if (negate_op_in && lookup_en)
      begin
         calc_c = ~word_zero;
         calc_v = (alu_output_mux_in == `SRCC_NEG_OVF);
      end
      if (load_status_in)
      begin
         if (computed_sel)
         begin
            state_next.flag_n = nz_neg;
            state_next.flag_z = nz_zero;
            state_next.flag_v = calc_v;
            state_next.flag_c = calc_c;
         end
         else
         begin
            state_next.flag_n = alu_output_mux_in[`SRCC_ALU_OUTPUT_MUX_N];
            state_next.flag_z = alu_output_mux_in[`SRCC_ALU_OUTPUT_MUX_Z];
            state_next.flag_v = alu_output_mux_in[`SRCC_ALU_OUTPUT_MUX_V];
            state_next.flag_c = alu_output_mux_in[`SRCC_ALU_OUTPUT_MUX_C];
         end
      end
      state_next.serial = rot.serial_in;
   end

   always_ff @(posedge clk_in)
   begin
      if (rst_in)
      begin
         state_reg <= '{flag_n: `SRCC_FLAG_RST, flag_z: `SRCC_FLAG_RST,
                        flag_v: `SRCC_FLAG_RST, flag_c: `SRCC_FLAG_RST,
                        serial: `SRCC_SERIAL_ZERO};
      end
      else
      begin
         state_reg <= state_next;
      end
   end

   assign flag_n_out = state_reg.flag_n;
   assign flag_z_out = state_reg.flag_z;
   assign flag_v_out = state_reg.flag_v;
   assign flag_c_out = state_reg.flag_c;
   // Registered copy: the B register sees the serial bit one cycle after the
   // select, a limitation of keeping every output on a flip-flop.
   assign serial_shift_in_out = state_reg.serial;

   //---------------------------------------------------------------------------
   // Checks
   //---------------------------------------------------------------------------
   default clocking cb @(posedge clk_in);
   endclocking
   default disable iff (rst_in);

   logic shift_load;
   assign shift_load = load_status_in & computed_sel & rotate_category_in;

   asr_carry_a: assert property (
      shift_load && rot_sel == SRCC_ASR |=> flag_c_out == $past(b_register_in[0]))
      else $error("shift-right carry is not bit 00");

   lookup_off_a: assert property (
      shift_load && rot_sel == SRCC_ASR && arith_carry_in && arith_overflow_in
      |=> flag_c_out == $past(b_register_in[0]) && flag_v_out == (flag_n_out ^ flag_c_out))
      else $error("lookup leaked into shift-right flags");

   left_neg_a: assert property (
      shift_load && !byte_operation_in && (rot_sel == SRCC_ASL || rot_sel == SRCC_ROL)
      |=> flag_n_out == $past(left_shift_sign_in))
      else $error("left shift negative is not the shift sign");

   ror_neg_a: assert property (
      shift_load && !byte_operation_in && rot_sel == SRCC_ROR
      |=> flag_n_out == $past(flag_c_out))
      else $error("rotate-right negative is not the old carry");

   asr_neg_a: assert property (
      shift_load && !byte_operation_in && rot_sel == SRCC_ASR
      |=> flag_n_out == $past(b_register_in[15]))
      else $error("shift-right negative is not bit 15");

   serial_bit_a: assert property (
      ##1 serial_shift_in_out == ($past(rot_sel) == SRCC_ASL ? 1'h0 :
                                  $past(rot_sel) == SRCC_ASR ? $past(b_register_in[15]) :
                                  $past(flag_c_out)))
      else $error("serial shift bit is wrong");

   shift_ovf_a: assert property (
      shift_load |=> flag_v_out == (flag_n_out ^ flag_c_out))
      else $error("shift overflow is not N xor C");

   asl_zero_a: assert property (
      shift_load && !byte_operation_in && rot_sel == SRCC_ASL
      |=> flag_z_out == ($past(b_leg_a_in[14:0]) == 15'h0000))
      else $error("shift-left zero is wrong");

   negate_flags_a: assert property (
      load_status_in && computed_sel && negate_op_in && !rotate_category_in
      && !byte_operation_in
      |=> flag_c_out == ($past(alu_output_mux_in) != 16'h0000)
          && flag_v_out == ($past(alu_output_mux_in) == 16'h8000)
          && flag_n_out == $past(alu_output_mux_in[15]))
      else $error("negate flags are wrong");

   word_zero_a: assert property (
      load_status_in && computed_sel && !rotate_category_in && !byte_operation_in
      |=> flag_z_out == ($past(alu_output_mux_in) == 16'h0000))
      else $error("word zero flag is wrong");

   flag_hold_a: assert property (
      !load_status_in |=> $stable({flag_n_out, flag_z_out, flag_v_out, flag_c_out}))
      else $error("flags changed without a load");

   direct_load_a: assert property (
      load_status_in && !computed_sel
      |=> {flag_n_out, flag_z_out, flag_v_out, flag_c_out} == $past(alu_output_mux_in[3:0]))
      else $error("direct flag load is wrong");

   //---------------------------------------------------------------------------
   // Per-operation carry, zero and negative sources
   //---------------------------------------------------------------------------
   // These pin each selector leg on its own, so a swapped leg cannot hide.
   rol_carry_a: assert property (
      shift_load && rot_sel == SRCC_ROL
      |=> flag_c_out == $past(b_register_in[15]))
      else $error("rotate-left carry is not bit 15");

   asl_carry_a: assert property (
      shift_load && rot_sel == SRCC_ASL
      |=> flag_c_out == $past(b_register_in[15]))
      else $error("shift-left carry is not bit 15");

   ror_carry_a: assert property (
      shift_load && rot_sel == SRCC_ROR
      |=> flag_c_out == $past(b_register_in[0]))
      else $error("rotate-right carry is not bit 00");

   asr_zero_a: assert property (
      shift_load && !byte_operation_in && rot_sel == SRCC_ASR
      |=> flag_z_out == ($past(b_leg_a_in[15:1]) == 15'h0000))
      else $error("shift-right zero is wrong");

   rot_zero_a: assert property (
      shift_load && !byte_operation_in && (rot_sel == SRCC_ROL || rot_sel == SRCC_ROR)
      |=> flag_z_out == (!$past(b_leg_a_in[15]) && !$past(flag_c_out)
                         && $past(b_leg_a_in[14:1]) == 14'h0000))
      else $error("rotate zero is wrong");

   byte_shift_zero_a: assert property (
      shift_load && byte_operation_in && rot_sel == SRCC_ASL
      |=> flag_z_out == ($past(b_leg_a_in[6:0]) == 7'h00))
      else $error("byte shift-left zero is wrong");

   byte_nz_a: assert property (
      load_status_in && computed_sel && byte_operation_in && !rotate_category_in
      |=> flag_n_out == $past(alu_output_mux_in[7])
          && flag_z_out == ($past(alu_output_mux_in[7:0]) == 8'h00))
      else $error("byte negative or zero is wrong");

   byte_rot_neg_a: assert property (
      shift_load && byte_operation_in && rot_sel == SRCC_ASR
      |=> flag_n_out == $past(b_register_in[15]))
      else $error("byte shift-right negative is not bit 15");

   lookup_used_a: assert property (
      load_status_in && computed_sel && !rotate_category_in && !negate_op_in
      |=> flag_c_out == $past(arith_carry_in) && flag_v_out == $past(arith_overflow_in))
      else $error("plain carry or overflow is not the lookup");

   asr_cov: cover property (shift_load && rot_sel == SRCC_ASR);
   asl_cov: cover property (shift_load && rot_sel == SRCC_ASL ##1 flag_z_out);
   rol_cov: cover property (shift_load && rot_sel == SRCC_ROL ##1 flag_v_out);
   neg_ovf_cov: cover property (load_status_in && computed_sel && negate_op_in
                                && alu_output_mux_in == 16'h8000);
   direct_cov: cover property (load_status_in && !computed_sel);

endmodule // srcc_top

`default_nettype wire

/* srcc_ctl_model.sv */
/*
 * Behavioural model of the microprogram sequencer that feeds the block:
 * builds the control store word for each step.
 * Assumes the bench changes its requests just after a falling clock edge.
 */
`default_nettype none
`include "srcc_params.svh"

module srcc_ctl_model
(
   // Step request from the bench
   input wire logic [1:0] shift_sel_in,
   input wire logic direct_load_in,
   // Microword toward the block
   output logic [31:0] microword_out
);
   timeunit 1ns;
   timeprecision 1ps;
   import srcc_pkg::*;

   // Unused fields carry a busy pattern so that no stray bit looks idle.
   localparam logic [31:0] FILL_WORD = 32'hA5C3_96E1;

   always_comb
   begin
      microword_out = FILL_WORD;
      // A flag step never also asks for an ALU function, so the field is free.
      microword_out[`SRCC_CS_S1_BIT] = ~shift_sel_in[1];
      microword_out[`SRCC_CS_S0_BIT] = ~shift_sel_in[0];
      microword_out[`SRCC_CS_AUX_BIT] = direct_load_in;
   end
endmodule // srcc_ctl_model

`default_nettype wire

/* srcc_top_test.sv */
/*
 * Self-checking bench for srcc_top: shift, rotate, plain, negate, direct
 * and hold steps, compared against the bench's own flag model.
 * Assumes srcc_pkg and srcc_ctl_model are compiled first.
 */
`default_nettype none

module srcc_top_test;
   timeunit 1ns;
   timeprecision 1ps;
   import srcc_pkg::*;

   logic clk_in = 1'h0;
   logic rst_in = 1'h1;
   logic ld = 1'h0, byt = 1'h0, rot = 1'h0, ng = 1'h0, dir = 1'h0;
   logic ls = 1'h0, ac = 1'h0, av = 1'h0;
   logic [1:0] sel = 2'h0;
   logic [15:0] am = 16'h0000, br = 16'h0000, bl = 16'h0000;
   logic [31:0] mw;
   logic n, z, v, c, ser;
   logic [3:0] ef = 4'h0;
   logic es = 1'h0;
   int failures = 0, n_checks = 0;

   always #12.5 clk_in = ~clk_in;

   srcc_ctl_model ctl (.shift_sel_in(sel), .direct_load_in(dir), .microword_out(mw));

   srcc_top DUT (.clk_in(clk_in), .rst_in(rst_in), .microword_in(mw), .load_status_in(ld),
      .byte_operation_in(byt), .rotate_category_in(rot), .negate_op_in(ng),
      .alu_output_mux_in(am), .b_register_in(br), .b_leg_a_in(bl),
      .left_shift_sign_in(ls), .arith_carry_in(ac), .arith_overflow_in(av),
      .flag_n_out(n), .flag_z_out(z), .flag_v_out(v), .flag_c_out(c),
      .serial_shift_in_out(ser));

   task automatic check(input logic [15:0] got, input logic [15:0] exp);
      n_checks++;
      if (got !== exp)
      begin
         failures++;
         $display("mismatch at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   // One step: drive at the falling edge, judge just after the rising edge.
   task automatic step(input logic [1:0] s, input logic b, r, g, d, l,
      input logic [15:0] a, bx, lx, input logic sg, cy, ov);
      logic rn, en, co, nn, zz, cc, vv, se;
      @(negedge clk_in);
      sel = s;
      byt = b;
      rot = r;
      ng = g;
      dir = d;
      ld = l;
      am = a;
      br = bx;
      bl = lx;
      ls = sg;
      ac = cy;
      av = ov;
      co = s[1] ? bx[15] : bx[0];
      case (s)
         SRCC_ROR: {rn, en, se} = {ef[0], ~(lx[15] | ef[0]), ef[0]};
         SRCC_ASR: {rn, en, se} = {bx[15], ~lx[15], bx[15]};
         SRCC_ROL: {rn, en, se} = {sg, ~(lx[15] | ef[0]), ef[0]};
         default: {rn, en, se} = {sg, ~lx[0], 1'h0};
      endcase
      case ({b, r})
         2'h0: {nn, zz} = {a[15], a == 16'h0000};
         2'h1: {nn, zz} = {rn, en & (lx[14:1] == 14'h0000)};
         2'h2: {nn, zz} = {a[7], a[7:0] == 8'h00};
         default: {nn, zz} = {rn, en & (lx[6:1] == 6'h00)};
      endcase
      {cc, vv} = r ? {co, nn ^ co} : (g ? {a != 16'h0000, a == 16'h8000} : {cy, ov});
      @(posedge clk_in);
      #1;
      if (l)
         ef = d ? a[3:0] : {nn, zz, vv, cc};
      es = se;
      check({12'h000, n, z, v, c}, {12'h000, ef});
      check({15'h0000, ser}, {15'h0000, es});
   endtask

   // Every select code, word and byte, with lookup and result bits set against us.
   task automatic test_shifts();
      logic [15:0] bt [5] = '{16'h8001, 16'h0000, 16'h7FFE, 16'h8000, 16'h0001};
      logic [15:0] lt [5] = '{16'h0000, 16'h8000, 16'h0001, 16'h0002, 16'h8001};
      for (int y = 0; y < 2; y++)
         for (int k = 0; k < 4; k++)
            for (int i = 0; i < 5; i++)
               step(k[1:0], y[0], 1'h1, 1'h0, 1'h0, 1'h1, ~bt[i], bt[i],
                  lt[i] | (y[0] ? 16'h7F80 : 16'h0000), i[0], 1'h1, 1'h1);
   endtask

   // Plain word, plain byte and negate steps.
   task automatic test_plain();
      logic [15:0] at [5] = '{16'h0000, 16'h8000, 16'h0100, 16'h0080, 16'h0200};
      for (int j = 0; j < 3; j++)
         for (int i = 0; i < 5; i++)
            step(i[1:0], j == 1, 1'h0, j == 2, 1'h0, 1'h1, at[i], ~at[i], at[i],
               i[0], i[0], i[1]);
   endtask

   // Direct load from the result word while a rotate is also decoded.
   task automatic test_direct();
      logic [15:0] at [4] = '{16'h000A, 16'h0005, 16'hFFF0, 16'h000F};
      for (int i = 0; i < 4; i++)
         step(i[1:0], 1'h0, 1'h1, 1'h0, 1'h1, 1'h1, at[i], 16'h8001, 16'h0000, 1'h1, 1'h0, 1'h0);
   endtask

   // No load strobe: flags hold while the serial bit keeps following; then a reset.
   task automatic test_hold();
      step(SRCC_ASL, 1'h0, 1'h1, 1'h0, 1'h0, 1'h1, 16'h0000, 16'h8000, 16'h0000, 1'h1, 1'h0, 1'h0);
      for (int k = 0; k < 4; k++)
         step(k[1:0], 1'h0, 1'h1, 1'h0, 1'h0, 1'h0, 16'h0000, 16'h0001, 16'h0000, 1'h0, 1'h1, 1'h1);
      @(negedge clk_in);
      rst_in = 1'h1;
      @(posedge clk_in);
      #1;
      ef = 4'h0;
      es = 1'h0;
      check({11'h000, n, z, v, c, ser}, 16'h0000);
      @(negedge clk_in);
      rst_in = 1'h0;
      step(SRCC_ROR, 1'h0, 1'h1, 1'h0, 1'h0, 1'h1, 16'h0000, 16'h0001, 16'h0000, 1'h0, 1'h0, 1'h0);
   endtask

   task automatic finish_test();
      $display("checks %0d failures %0d", n_checks, failures);
      if (failures == 0 && n_checks > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask

   initial
   begin
      repeat (8) @(posedge clk_in);
      #1;
      check({11'h000, n, z, v, c, ser}, 16'h0000);
      @(negedge clk_in);
      rst_in = 1'h0;
      test_shifts();
      test_plain();
      test_direct();
      test_hold();
      finish_test();
   end

   initial
   begin
      repeat (3000) @(posedge clk_in);
      failures++;
      finish_test();
   end
endmodule // srcc_top_test

`default_nettype wire
